// ===== src/package_engine.sv
// Device end: defines, stores and returns measurand packages
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
// Function
// R1 - Define request first byte is 0x30
// R2 - Define request byte one is package number
// R3 - Define length upper nibble, selector lower nibble
// R4 - Package values fit twelve bytes total
// R5 - Build package from identifiers in order
// R6 - Ignore request error nibble and common status
// R7 - Reply status nibble, echoed type, common status
// R8 - First byte bit seven always zero
// R9 - Echo package number in byte one
// R10 - Define reply reports zero length
// R11 - Fetch request first byte is 0x20
// R12 - Fetch request byte one names package
// R13 - Fetch length nibble zero, selector lower
// R14 - Fetch reply length is returned byte count
// R15 - Fetch reply echoes dataset selector
// R16 - Fetch reply carries formatted measured values
// R17 - Telegram type codes as listed
// R18 - Package zero request fetches package 0
// R19 - Sixteen byte telegrams, excess bytes ignored
// R20 - Definitions stored per package number
module package_engine
  import tel_pkg::*;
#(
  parameter int NUM_PKG = 16
)(
  input wire logic pclk, // Clock, 125 MHz
  input wire logic presetn, // Async reset, active low
  telegram_if.device_mp tl, // Telegram channel
  output logic [7:0] val_id, // Measurand identifier being looked up
  output logic [3:0] val_ds, // Dataset selector of lookup
  input wire logic [31:0] val_data, // Formatted value for val_id, low-aligned
  input wire logic [2:0] val_len, // Its size in bytes
  input wire logic [7:0] common_status // Common status to report
);
  localparam int PW = $clog2(NUM_PKG);

  typedef enum logic [1:0] {IDLE, LOOK, REPLY} eng_state_e;

  eng_state_e state_r;
  logic [2:0] type_r;
  logic [7:0] pkg_r;
  logic [3:0] ds_r;
  logic [3:0] cst_r;
  logic [3:0] idx_r;
  logic [3:0] fill_r;
  logic [95:0] buf_r;
  logic rsp_valid_r;
  logic [127:0] rsp_tel_r;
  logic [7:0] val_id_r;
  logic [3:0] val_ds_r;
  logic [7:0] ids_r [NUM_PKG][UD_BYTES];
  logic [3:0] cnt_r [NUM_PKG];
  logic [NUM_PKG-1:0] defd_r;

  ////////////////////////////////////////////////////////////////////////
  // Request decode
  logic take;
  logic [2:0] rq_type;
  logic [7:0] rq_pkg;
  logic [3:0] rq_len;
  logic [3:0] rq_ds;
  logic [7:0] look_pkg;
  logic is_define;
  logic is_fetch;
  logic pkg_ok;
  logic [PW-1:0] pidx;
  logic [PW-1:0] cur_pidx;
  logic len_ok;
  logic [95:0] rq_ud;

  // No retake while the previous answer is still on the channel
  assign take = (state_r == IDLE) && tl.req_valid && !rsp_valid_r;
  assign rq_type = tl.req_tel[B0_LSB + TYPE_LSB +: 3]; // R17 R6
  assign rq_pkg = tl.req_tel[B1_LSB +: 8]; // R2 R12
  assign rq_len = tl.req_tel[B2_LSB + 4 +: 4]; // R3
  assign rq_ds = tl.req_tel[B2_LSB +: 4]; // R3 R13
  assign rq_ud = tl.req_tel[UD_W-1:0]; // R19
  assign is_define = rq_type == TYPE_DEFINE; // R1
  assign is_fetch = (rq_type == TYPE_FETCH) || (rq_type == TYPE_ZERO); // R11 R18
  assign look_pkg = (rq_type == TYPE_ZERO) ? ZERO_PKG : rq_pkg; // R18
  assign pkg_ok = look_pkg < 8'(NUM_PKG);
  assign pidx = look_pkg[PW-1:0];
  assign cur_pidx = pkg_r[PW-1:0];
  assign len_ok = rq_len <= 4'(UD_BYTES); // R4

  ////////////////////////////////////////////////////////////////////////
  // Packing of looked-up values
  logic [95:0] pk_buf;
  logic [3:0] pk_fill;
  logic pk_fits;
  logic [3:0] idx_nxt;
  logic last;

  value_packer u_packer (
    .buf_in(buf_r),
    .fill_in(fill_r),
    .val(val_data),
    .len(val_len),
    .buf_out(pk_buf),
    .fill_out(pk_fill),
    .fits(pk_fits)
  );

  assign idx_nxt = idx_r + 4'h1;
  assign last = idx_nxt >= cnt_r[cur_pidx];

  ////////////////////////////////////////////////////////////////////////
  // Response assembly
  logic define_rsp;
  logic [3:0] rsp_len;
  logic [95:0] rsp_ud;
  logic [127:0] rsp_word;

  assign define_rsp = type_r == TYPE_DEFINE;
  assign rsp_len = define_rsp ? NIBBLE_ZERO : fill_r; // R10 R14
  assign rsp_ud = define_rsp ? 96'h0 : buf_r; // R10 R16
  assign rsp_word = {RESERVED_BIT, type_r, cst_r, pkg_r, rsp_len, ds_r, // R7 R8 R9 R15
                     common_status, rsp_ud}; // R7

  ////////////////////////////////////////////////////////////////////////
  // Package store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      defd_r <= '0;
    end else if (take && is_define && pkg_ok && len_ok) begin
      defd_r[pidx] <= 1'b1; // R20
    end
  end

  // Identifiers in request order; unused slots are don't-care
  always_ff @(posedge pclk) begin
    if (take && is_define && pkg_ok && len_ok) begin
      cnt_r[pidx] <= rq_len; // R5 R20
      for (int i = 0; i < UD_BYTES; i++) begin
        ids_r[pidx][i] <= rq_ud[UD_W - 8 - 8 * i +: 8]; // R5
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= IDLE;
      type_r <= TYPE_ZERO;
      pkg_r <= ZERO_PKG;
      ds_r <= NIBBLE_ZERO;
      cst_r <= CST_OK;
      idx_r <= NIBBLE_ZERO;
      fill_r <= NIBBLE_ZERO;
      buf_r <= '0;
      val_id_r <= ZERO_PKG;
      val_ds_r <= NIBBLE_ZERO;
    end else begin
      unique case (state_r)
        IDLE: begin
          if (take) begin
            type_r <= rq_type;
            pkg_r <= look_pkg; // R9
            ds_r <= is_define ? rq_ds : rq_ds; // R15
            val_ds_r <= rq_ds;
            idx_r <= NIBBLE_ZERO;
            fill_r <= NIBBLE_ZERO;
            buf_r <= '0;
            state_r <= REPLY;
            val_id_r <= ids_r[pidx][0];
            if (!is_define && !is_fetch) begin
              cst_r <= CST_BAD_TYPE;
            end else if (!pkg_ok) begin
              cst_r <= CST_BAD_PKG;
            end else if (is_define) begin
              cst_r <= len_ok ? CST_OK : CST_TOO_LONG; // R4
            end else if (!defd_r[pidx]) begin
              cst_r <= CST_UNDEF;
            end else begin
              cst_r <= CST_OK;
              if (cnt_r[pidx] != NIBBLE_ZERO) begin
                state_r <= LOOK;
              end
            end
          end
        end
        LOOK: begin
          // One value per cycle; the source answers val_id combinationally
          if (!pk_fits) begin
            cst_r <= CST_TOO_LONG; // R4
            state_r <= REPLY;
          end else begin
            buf_r <= pk_buf; // R16
            fill_r <= pk_fill; // R14
            idx_r <= idx_nxt;
            // Past the last id the index may leave the array
            if (last) begin
              state_r <= REPLY;
            end else begin
              val_id_r <= ids_r[cur_pidx][idx_nxt]; // R5
            end
          end
        end
        REPLY: begin
          state_r <= IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_r <= 1'b0;
      rsp_tel_r <= '0;
    end else begin
      rsp_valid_r <= state_r == REPLY;
      if (state_r == REPLY) begin
        rsp_tel_r <= rsp_word; // R7
      end
    end
  end

  assign tl.rsp_valid = rsp_valid_r;
  assign tl.rsp_tel = rsp_tel_r;
  assign val_id = val_id_r;
  assign val_ds = val_ds_r;
endmodule

// ===== src/tel_pkg.sv
// Telegram layout, type codes, status codes and requester register map
package tel_pkg;
  localparam int TEL_W = 128;
  localparam int UD_BYTES = 12;
  localparam int UD_W = 96;
  // Bit positions of header bytes in a telegram word, B0 uppermost
  localparam int B0_LSB = 120;
  localparam int B1_LSB = 112;
  localparam int B2_LSB = 104;
  localparam int B3_LSB = 96;
  localparam int TYPE_LSB = 4;
  localparam logic [2:0] TYPE_ZERO = 3'h0;
  localparam logic [2:0] TYPE_VALUE = 3'h1;
  localparam logic [2:0] TYPE_FETCH = 3'h2;
  localparam logic [2:0] TYPE_DEFINE = 3'h3;
  localparam logic [2:0] TYPE_CMD = 3'h4;
  localparam logic [2:0] TYPE_PARAM = 3'h6;
  localparam logic RESERVED_BIT = 1'b0;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam logic [7:0] COMMON_REQ = 8'h00;
  localparam logic [7:0] ZERO_PKG = 8'h00;
  // Communication status codes
  localparam logic [3:0] CST_OK = 4'h0;
  localparam logic [3:0] CST_BAD_TYPE = 4'h1;
  localparam logic [3:0] CST_BAD_PKG = 4'h2;
  localparam logic [3:0] CST_TOO_LONG = 4'h3;
  localparam logic [3:0] CST_UNDEF = 4'h4;
  // Requester registers on APB
  localparam logic [7:0] REG_REQ_HDR = 8'h00;
  localparam logic [7:0] REG_REQ_D0 = 8'h04;
  localparam logic [7:0] REG_REQ_D1 = 8'h08;
  localparam logic [7:0] REG_REQ_D2 = 8'h0C;
  localparam logic [7:0] REG_CTRL = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RSP_HDR = 8'h18;
  localparam logic [7:0] REG_RSP_D0 = 8'h1C;
  localparam logic [7:0] REG_RSP_D1 = 8'h20;
  localparam logic [7:0] REG_RSP_D2 = 8'h24;
  localparam int CTRL_SEND = 0;
  localparam int CTRL_AUTO = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage

// ===== src/telegram_if.sv
// Cyclic telegram channel between requester and package engine
`timescale 1ns/1ns
interface telegram_if;
  logic req_valid;
  logic [127:0] req_tel;
  logic rsp_valid;
  logic [127:0] rsp_tel;
  modport device_mp (input req_valid, input req_tel, output rsp_valid, output rsp_tel);
  modport host_mp (output req_valid, output req_tel, input rsp_valid, input rsp_tel);
endinterface

// ===== src/value_packer.sv
// Places one measured value big-endian into the user data area
`timescale 1ns/1ns
module value_packer
  import tel_pkg::*;
(
  input wire logic [95:0] buf_in, // User data so far, D00 uppermost
  input wire logic [3:0] fill_in, // Bytes already used
  input wire logic [31:0] val, // Value, low-aligned
  input wire logic [2:0] len, // Value size in bytes
  output logic [95:0] buf_out, // User data with value added
  output logic [3:0] fill_out, // Bytes used afterwards
  output logic fits // Value fits in the area
);
  logic [4:0] total;
  assign total = {1'b0, fill_in} + {2'b00, len};
  assign fits = total <= 5'(UD_BYTES);
  assign fill_out = total[3:0];

  always_comb begin
    int k;
    k = 0;
    buf_out = buf_in;
    for (int j = 0; j < UD_BYTES; j++) begin
      k = j - int'(fill_in);
      if (k >= 0 && k < int'(len)) begin
        buf_out[UD_W - 8 - 8 * j +: 8] = val[8 * (int'(len) - 1 - k) +: 8];
      end
    end
  end
endmodule

// ===== src/telegram_requester.sv
// Head-module end: APB registers that issue telegrams and hold replies
`timescale 1ns/1ns
module telegram_requester
  import tel_pkg::*;
(
  input wire logic pclk, // Clock, 125 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  telegram_if.host_mp tl // Telegram channel
);
  logic [31:0] hdr_r;
  logic [95:0] data_r;
  logic auto_r;
  logic busy_r;
  logic done_r;
  logic [127:0] rsp_r;
  logic req_valid_r;
  logic [127:0] req_tel_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;

  ////////////////////////////////////////////////////////////////////////
  // APB decode
  logic setup;
  logic wr;
  logic hit;
  logic [31:0] rd_mux;
  logic send;
  logic auto_go;
  logic start;
  logic [2:0] sw_type;
  logic fetch_like;
  logic [127:0] sw_tel;
  logic [127:0] zero_tel;

  assign setup = psel && !penable;
  assign wr = psel && penable && pready_r && pwrite && hit;
  assign hit = (paddr <= REG_RSP_D2) && (paddr[1:0] == 2'b00);
  assign rd_mux = (paddr == REG_REQ_HDR) ? hdr_r :
                  (paddr == REG_REQ_D0) ? data_r[95:64] :
                  (paddr == REG_REQ_D1) ? data_r[63:32] :
                  (paddr == REG_REQ_D2) ? data_r[31:0] :
                  (paddr == REG_CTRL) ? {30'h0, auto_r, 1'b0} :
                  (paddr == REG_STATUS) ? {30'h0, done_r, busy_r} :
                  (paddr == REG_RSP_HDR) ? rsp_r[127:96] :
                  (paddr == REG_RSP_D0) ? rsp_r[95:64] :
                  (paddr == REG_RSP_D1) ? rsp_r[63:32] :
                  (paddr == REG_RSP_D2) ? rsp_r[31:0] : WORD_ZERO;

  ////////////////////////////////////////////////////////////////////////
  // Request building
  assign send = wr && (paddr == REG_CTRL) && pwdata[CTRL_SEND];
  assign auto_go = auto_r && !send;
  assign start = !busy_r && (send || auto_go);
  assign sw_type = hdr_r[30:28];
  assign fetch_like = (sw_type == TYPE_FETCH) || (sw_type == TYPE_ZERO);
  // Error nibble and common status are always sent as zero
  assign sw_tel = {RESERVED_BIT, sw_type, NIBBLE_ZERO, hdr_r[23:16], // R8 R1 R11 R2 R12
                   fetch_like ? NIBBLE_ZERO : hdr_r[15:12], hdr_r[11:8], // R3 R13
                   COMMON_REQ, data_r}; // R5 R19
  assign zero_tel = {RESERVED_BIT, TYPE_ZERO, NIBBLE_ZERO, ZERO_PKG, // R18 R17
                     NIBBLE_ZERO, NIBBLE_ZERO, COMMON_REQ, 96'h0};

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hdr_r <= WORD_ZERO;
      data_r <= '0;
      auto_r <= 1'b0;
    end else if (wr) begin
      if (paddr == REG_REQ_HDR) hdr_r <= pwdata;
      if (paddr == REG_REQ_D0) data_r[95:64] <= pwdata;
      if (paddr == REG_REQ_D1) data_r[63:32] <= pwdata;
      if (paddr == REG_REQ_D2) data_r[31:0] <= pwdata;
      if (paddr == REG_CTRL) auto_r <= pwdata[CTRL_AUTO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel handshake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      req_valid_r <= 1'b0;
      req_tel_r <= '0;
      rsp_r <= '0;
    end else begin
      if (start) begin
        busy_r <= 1'b1;
        req_valid_r <= 1'b1;
        req_tel_r <= send ? sw_tel : zero_tel;
      end else if (busy_r && tl.rsp_valid) begin
        busy_r <= 1'b0;
        req_valid_r <= 1'b0;
        rsp_r <= tl.rsp_tel;
      end
      // A reply in the clearing cycle keeps done set
      if (busy_r && tl.rsp_valid) begin
        done_r <= 1'b1;
      end else if (wr && (paddr == REG_STATUS) && pwdata[STAT_DONE]) begin
        done_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB answer, registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= WORD_ZERO;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= setup;
      pslverr_r <= setup && !hit;
      if (setup) begin
        prdata_r <= rd_mux;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign tl.req_valid = req_valid_r;
  assign tl.req_tel = req_tel_r;
endmodule

// ===== tb/telegram_properties.sv
// Concurrent checks on the telegram channel between the two ends
`timescale 1ns/1ns
module telegram_properties
  import tel_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic req_valid, // Request pending
  input wire logic [127:0] req_tel, // Request telegram
  input wire logic rsp_valid, // Reply pulse
  input wire logic [127:0] rsp_tel // Reply telegram
);
  wire [2:0] req_type = req_tel[126:124];
  wire [3:0] req_len = req_tel[111:108];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  a_reserved_zero: assert property (rsp_valid |-> rsp_tel[127] == RESERVED_BIT)
    else $error("reply reserved bit set");
  a_type_echo: assert property (rsp_valid |-> rsp_tel[126:124] == req_type)
    else $error("reply type differs from request");
  a_number_echo: assert property (
    rsp_valid && req_type != TYPE_ZERO |-> rsp_tel[119:112] == req_tel[119:112])
    else $error("reply package number differs");
  a_zero_fetch: assert property (
    rsp_valid && req_type == TYPE_ZERO |-> rsp_tel[119:112] == ZERO_PKG)
    else $error("package zero reply names other package");
  a_define_len: assert property (
    rsp_valid && req_type == TYPE_DEFINE |-> rsp_tel[111:108] == NIBBLE_ZERO)
    else $error("define reply length not zero");
  a_fetch_sel: assert property (
    rsp_valid && req_type == TYPE_FETCH |-> rsp_tel[107:104] == req_tel[107:104])
    else $error("fetch reply selector differs");
  a_fill_limit: assert property (rsp_valid |-> rsp_tel[111:108] <= 4'hC)
    else $error("reply length above twelve");
  a_too_long: assert property (
    rsp_valid && req_type == TYPE_DEFINE && req_len > 4'hC
    |-> rsp_tel[123:120] == CST_TOO_LONG)
    else $error("overlong define not refused");
  // Define needs no lookups, so its reply is quick
  a_define_time: assert property (
    $rose(req_valid) && req_type == TYPE_DEFINE |-> ##[1:4] rsp_valid)
    else $error("define reply late");
  a_reply_pulse: assert property (rsp_valid |=> !rsp_valid && !req_valid)
    else $error("reply pulse or request not released");
endmodule

// ===== tb/testbench.sv
// Bench: APB driven requester talking to the package engine
`timescale 1ns/1ns
`define CHK(a, e) \
  begin \
    checked++; \
    if ((a) !== (e)) begin \
      n_errors++; \
      $display("[FAIL] %0t got %0h expected %0h", $time, (a), (e)); \
    end \
  end
module testbench;
  import tel_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr;
  logic [7:0] val_id;
  logic [7:0] cs = 8'h00;
  logic [3:0] val_ds;
  logic [31:0] val_data;
  logic [2:0] val_len;
  int n_errors = 0;
  int checked = 0;

  always #4 pclk = ~pclk;

  // Value source: size 1..4 from the id, bytes derived from id and selector
  function automatic logic [7:0] vbyte(logic [7:0] id, logic [3:0] ds, int b);
    return id + 8'(b) + {ds, 4'h0};
  endfunction
  assign val_len = {1'b0, val_id[1:0]} + 3'h1;
  assign val_data = {vbyte(val_id, val_ds, 3), vbyte(val_id, val_ds, 2),
                     vbyte(val_id, val_ds, 1), vbyte(val_id, val_ds, 0)};

  telegram_if tl_if();
  package_engine #(.NUM_PKG(16)) package_engine_inst (.pclk(pclk), .presetn(presetn),
    .tl(tl_if.device_mp), .val_id(val_id), .val_ds(val_ds), .val_data(val_data),
    .val_len(val_len), .common_status(cs));
  telegram_requester telegram_requester_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tl(tl_if.host_mp));
  telegram_properties telegram_properties_inst (.pclk(pclk), .presetn(presetn),
    .req_valid(tl_if.req_valid), .req_tel(tl_if.req_tel), .rsp_valid(tl_if.rsp_valid),
    .rsp_tel(tl_if.rsp_tel));

  ////////////////////////////////////////////////////////////////////////////
  // Request held until the rising edge that samples ready high; data taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, rerr);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, WORD_ZERO, rdat, rerr);
    `CHK(rdat, e)
  endtask

  // No count of its own: a reply that never comes is left to the watchdog
  task automatic wait_done();
    do apb(1'b0, REG_STATUS, WORD_ZERO, rdat, rerr);
    while (rdat[STAT_DONE] !== 1'b1);
  endtask

  task automatic send(input logic [31:0] h, input logic [95:0] d);
    wr(REG_REQ_HDR, h);
    wr(REG_REQ_D0, d[95:64]);
    wr(REG_REQ_D1, d[63:32]);
    wr(REG_REQ_D2, d[31:0]);
    wr(REG_CTRL, 32'h0000_0001);
    wait_done();
    wr(REG_STATUS, 32'h0000_0002);
  endtask

  // Whole values only; the first value that would pass twelve bytes ends it
  function automatic logic [99:0] pack(logic [95:0] ids, int n, logic [3:0] ds);
    logic [95:0] ud;
    logic [7:0] id;
    int f;
    ud = '0;
    f = 0;
    for (int i = 0; i < n; i++) begin
      id = ids[95 - 8 * i -: 8];
      if (f + id[1:0] + 1 > 12) break;
      for (int b = id[1:0]; b >= 0; b--) begin
        ud[95 - 8 * f -: 8] = vbyte(id, ds, b);
        f++;
      end
    end
    return {4'(f), ud};
  endfunction

  task automatic fetch(input logic [2:0] t, input logic [7:0] p, input logic [95:0] ids,
                       input int n, input logic [3:0] ds, input logic [3:0] st);
    logic [99:0] e;
    send({1'b0, t, 4'h0, p, 4'h0, ds, 8'h00}, 96'h0);
    e = pack(ids, n, ds);
    rdchk(REG_RSP_HDR, {1'b0, t, st, p, e[99:96], ds, cs});
    rdchk(REG_RSP_D0, e[95:64]);
    rdchk(REG_RSP_D1, e[63:32]);
    rdchk(REG_RSP_D2, e[31:0]);
  endtask

  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    cs <= 8'h5A;
    rdchk(REG_RSP_HDR, WORD_ZERO);
    apb(1'b0, 8'h28, WORD_ZERO, rdat, rerr);
    `CHK(rerr, 1'b1)
    send(32'h3001_3500, {24'h030D0C, 72'h0});
    rdchk(REG_RSP_HDR, 32'h3001_055A);
    fetch(TYPE_FETCH, 8'h01, {24'h030D0C, 72'h0}, 3, 4'h2, CST_OK);
    send(32'h3002_D000, {96{1'b1}});
    rdchk(REG_RSP_HDR, 32'h3302_005A);
    send(32'h2002_0000, 96'h0);
    apb(1'b0, REG_RSP_HDR, WORD_ZERO, rdat, rerr);
    `CHK(rdat[31:16], {1'b0, TYPE_FETCH, CST_UNDEF, 8'h02})
    send(32'h3004_4000, {32'h03070B0F, 64'h0});
    cs <= 8'hA5;
    fetch(TYPE_FETCH, 8'h04, {32'h03070B0F, 64'h0}, 4, 4'h3, CST_TOO_LONG);
    fetch(TYPE_FETCH, 8'h01, {24'h030D0C, 72'h0}, 3, 4'h7, CST_OK);
    send(32'h2010_0000, 96'h0);
    apb(1'b0, REG_RSP_HDR, WORD_ZERO, rdat, rerr);
    `CHK(rdat[31:16], {1'b0, TYPE_FETCH, CST_BAD_PKG, 8'h10})
    send(32'h3000_2000, {16'h0E01, 80'h0});
    fetch(TYPE_ZERO, ZERO_PKG, {16'h0E01, 80'h0}, 2, 4'h0, CST_OK);
    for (int k = 0; k < 3; k++) begin
      logic [2:0] t;
      t = (k == 0) ? TYPE_VALUE : (k == 1) ? TYPE_CMD : TYPE_PARAM;
      send({1'b0, t, 4'h0, 24'h0100_00}, 96'h0);
      apb(1'b0, REG_RSP_HDR, WORD_ZERO, rdat, rerr);
      `CHK(rdat[31:16], {1'b0, t, CST_BAD_TYPE, 8'h01})
    end
    // Automatic package-zero requests; package 0 holds ids 0E and 01
    wr(REG_CTRL, 32'h0000_0002);
    wait_done();
    rdchk(REG_CTRL, 32'h0000_0002);
    rdchk(REG_RSP_HDR, 32'h0000_50A5);
    rdchk(REG_RSP_D0, 32'h100F_0E02);
    wr(REG_CTRL, WORD_ZERO);
    print_verdict();
  end

  initial begin
    #200000;
    n_errors++;
    $display("[FAIL] %0t timeout", $time);
    print_verdict();
  end
endmodule
